// file: rtl/fan_pkg.sv
// Overview of operation
// - control bit 0 forces fan pin high
// - duty value gives high steps per 64
// - two bits together pick fan frequency
// - multiplier bit doubles the chosen fan frequency
// - tach clock divided by 1, 2, 4, 8
// - 8-bit counter measures each tach pulse
// - count invalid up to two pulses after preload
// - preload write restarts the tach count logic
package fan_pkg;

	// ----------------------------------------
	// register map (index, byte address is 4x)
	// ----------------------------------------
	localparam int         IDX_W          = 8;
	localparam int         IDX_LSB        = 2;
	localparam int         ADDR_W         = 32;
	localparam logic [7:0] IDX_FAN_OUT    = 8'h56;
	localparam logic [7:0] IDX_FAN_CLK    = 8'h58;
	localparam logic [7:0] IDX_TACH_CNT   = 8'h59;
	localparam logic [7:0] IDX_TACH_START = 8'h5b;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_FAN_OUT    = 8'h00;
	localparam logic [7:0] RST_FAN_CLK    = 8'h10;
	localparam logic [7:0] RST_TACH_CNT   = 8'h00;
	localparam logic [7:0] RST_TACH_START = 8'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int         OUT_FORCE_BIT  = 0;
	localparam int         OUT_DUTY_LSB   = 1;
	localparam int         OUT_CLKSEL_BIT = 7;
	localparam int         CLK_SRC_BIT    = 0;
	localparam int         CLK_MULT_BIT   = 2;
	localparam int         CLK_DIV_LSB    = 4;
	// reserved bits of clock control read as zero
	localparam logic [7:0] CLK_WR_MASK    = 8'h35;

	// ----------------------------------------
	// widths and timing counts (in hclk cycles)
	// ----------------------------------------
	localparam int          DUTY_W        = 6;
	localparam int          TACH_W        = 8;
	localparam int          SCALE_W       = 3;
	localparam int          DIV_W         = 16;
	localparam int          DIV_MIN       = 4;
	localparam logic [15:0] PWM_DIV_DEF0  = 16'h0040;
	localparam logic [15:0] PWM_DIV_DEF1  = 16'h0080;
	localparam logic [15:0] PWM_DIV_DEF2  = 16'h0100;
	localparam logic [15:0] PWM_DIV_DEF3  = 16'h0200;
	localparam logic [15:0] TACH_DIV_DEF  = 16'h0064;

endpackage : fan_pkg

// file: rtl/tach_counter.sv
`timescale 1ns/1ns
module tach_counter #(
	parameter int WIDTH = fan_pkg::TACH_W
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// measurement control
	input  wire logic             count_tick,
	input  wire logic             pulse_edge,
	input  wire logic             restart,
	input  wire logic [WIDTH-1:0] preload,
	// result
	output logic      [WIDTH-1:0] latched_count
);

	localparam logic [WIDTH-1:0] ALL_ONES = '1;

	if (WIDTH < 2) begin : g_bad_width
		$error("tach counter width too small");
	end

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic             started_reg;
	logic [WIDTH-1:0] latched_reg;
	wire              at_top = (count_reg == ALL_ONES);
	wire              do_latch = pulse_edge && started_reg && !restart;
	wire [WIDTH-1:0]  base_val = (restart || pulse_edge) ? preload : count_reg;
	wire              base_top = (base_val == ALL_ONES);

	// load, restart, saturate
	// a tick on the edge cycle opens the new pulse, so no tick is lost
	assign count_next = (count_tick && !restart && !base_top) ? base_val + 1'b1 : base_val;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg   <= '0;
			started_reg <= 1'b0;
			latched_reg <= fan_pkg::RST_TACH_CNT;
		end else begin
			count_reg <= count_next;
			// no latch before a full pulse
			if (restart)
				started_reg <= 1'b0;
			else if (pulse_edge)
				started_reg <= 1'b1;
			// keep final count of last pulse
			if (do_latch)
				latched_reg <= count_reg;
		end
	end

	assign latched_count = latched_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_count_saturates : assert property (@(posedge hclk) disable iff (!hresetn)
		at_top && !restart && !pulse_edge |=> count_reg == ALL_ONES)
		else $error("tach count wrapped past all ones");

	a_edge_reloads : assert property (@(posedge hclk) disable iff (!hresetn)
		restart || (pulse_edge && !count_tick) |=> count_reg == $past(preload))
		else $error("tach count not reloaded from preload");

	a_edge_tick : assert property (@(posedge hclk) disable iff (!hresetn)
		pulse_edge && count_tick && !restart && preload != ALL_ONES |=> count_reg == $past(preload) + 1'b1)
		else $error("tick on the edge cycle was lost");

	a_latch_final : assert property (@(posedge hclk) disable iff (!hresetn)
		do_latch |=> latched_reg == $past(count_reg))
		else $error("latched count differs from final count");

	a_restart_disarms : assert property (@(posedge hclk) disable iff (!hresetn)
		restart ##1 !pulse_edge [*2] |-> latched_reg == $past(latched_reg, 2))
		else $error("count latched too early after restart");

	a_tick_counts : assert property (@(posedge hclk) disable iff (!hresetn)
		count_tick && !at_top && !restart && !pulse_edge |=> count_reg == $past(count_reg) + 1'b1)
		else $error("tach count missed a tick");

endmodule : tach_counter

// file: rtl/fan_pwm_and_tachometer.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
module fan_pwm_and_tachometer #(
	parameter logic [15:0] PWM_DIV0 = fan_pkg::PWM_DIV_DEF0,
	parameter logic [15:0] PWM_DIV1 = fan_pkg::PWM_DIV_DEF1,
	parameter logic [15:0] PWM_DIV2 = fan_pkg::PWM_DIV_DEF2,
	parameter logic [15:0] PWM_DIV3 = fan_pkg::PWM_DIV_DEF3,
	parameter logic [15:0] TACH_DIV = fan_pkg::TACH_DIV_DEF
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// fan pins
	input  wire logic        fan_tach_in,
	output logic             fan_pwm_out
);

	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	// halving by the multiplier must leave at least two cycles per step
	if (PWM_DIV0 < fan_pkg::DIV_MIN || PWM_DIV1 < fan_pkg::DIV_MIN ||
	    PWM_DIV2 < fan_pkg::DIV_MIN || PWM_DIV3 < fan_pkg::DIV_MIN ||
	    TACH_DIV < fan_pkg::DIV_MIN) begin : g_bad_div
		$error("fan divider parameters below minimum");
	end

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [2:0] scale_mask(input logic [1:0] code);
		case (code)
			2'b00:   scale_mask = 3'h0;
			2'b01:   scale_mask = 3'h1;
			2'b10:   scale_mask = 3'h3;
			2'b11:   scale_mask = 3'h7;
			default: scale_mask = 3'h0;
		endcase
	endfunction : scale_mask

	function automatic logic hits(input logic [7:0] idx, input logic [7:0] target);
		hits = (idx == target);
	endfunction : hits

	// ----------------------------------------
	// bus address phase
	// ----------------------------------------
	logic        wr_pend_reg;
	logic [7:0]  idx_reg;
	logic [31:0] hrdata_reg;
	logic        hreadyout_reg;
	logic        hresp_reg;

	logic [7:0]  fan_output_control_reg;
	logic [7:0]  fan_clock_control_reg;
	logic [7:0]  tach_start_value_reg;
	logic [7:0]  tach_pulse_count;

	wire         addr_take  = hsel && hready && htrans[1];
	wire  [7:0]  addr_idx   = haddr[fan_pkg::IDX_LSB +: fan_pkg::IDX_W];
	wire         addr_upper = (haddr[fan_pkg::ADDR_W-1:fan_pkg::IDX_LSB+fan_pkg::IDX_W] == '0);
	wire         addr_word  = (haddr[1:0] == 2'b00);
	wire  [7:0]  rd_idx     = (addr_upper && addr_word) ? addr_idx : 8'h00;

	wire         wr_out     = wr_pend_reg && hits(idx_reg, fan_pkg::IDX_FAN_OUT);
	wire         wr_clk     = wr_pend_reg && hits(idx_reg, fan_pkg::IDX_FAN_CLK);
	wire         wr_start   = wr_pend_reg && hits(idx_reg, fan_pkg::IDX_TACH_START);

	// unmapped indices read zero
	wire  [7:0]  rd_value   = hits(rd_idx, fan_pkg::IDX_FAN_OUT)    ? fan_output_control_reg :
	                          hits(rd_idx, fan_pkg::IDX_FAN_CLK)    ? fan_clock_control_reg :
	                          hits(rd_idx, fan_pkg::IDX_TACH_CNT)   ? tach_pulse_count :
	                          hits(rd_idx, fan_pkg::IDX_TACH_START) ? tach_start_value_reg : 8'h00;

	wire  [31:0] hrdata_next = (addr_take && !hwrite) ? {24'h000000, rd_value} : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg   <= 1'b0;
			idx_reg       <= 8'h00;
			hrdata_reg    <= 32'h00000000;
			hreadyout_reg <= 1'b0;
			hresp_reg     <= 1'b0;
		end else begin
			wr_pend_reg   <= addr_take && hwrite && addr_upper && addr_word;
			idx_reg       <= addr_take ? addr_idx : idx_reg;
			hrdata_reg    <= hrdata_next;
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end
	end

	assign hrdata    = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp     = hresp_reg;

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fan_output_control_reg <= fan_pkg::RST_FAN_OUT;
			fan_clock_control_reg  <= fan_pkg::RST_FAN_CLK;
			tach_start_value_reg   <= fan_pkg::RST_TACH_START;
		end else begin
			if (wr_out)
				fan_output_control_reg <= hwdata[7:0];
			if (wr_clk)
				fan_clock_control_reg <= hwdata[7:0] & fan_pkg::CLK_WR_MASK;
			if (wr_start)
				tach_start_value_reg <= hwdata[7:0];
		end
	end

	wire                      force_high = fan_output_control_reg[fan_pkg::OUT_FORCE_BIT];
	wire [fan_pkg::DUTY_W-1:0] duty      = fan_output_control_reg[fan_pkg::OUT_DUTY_LSB +: fan_pkg::DUTY_W];
	wire                      clk_sel    = fan_output_control_reg[fan_pkg::OUT_CLKSEL_BIT];
	wire                      clk_src    = fan_clock_control_reg[fan_pkg::CLK_SRC_BIT];
	wire                      clk_mult   = fan_clock_control_reg[fan_pkg::CLK_MULT_BIT];
	wire [1:0]                div_code   = fan_clock_control_reg[fan_pkg::CLK_DIV_LSB +: 2];

	// ----------------------------------------
	// pwm rate selection
	// ----------------------------------------
	logic [fan_pkg::DIV_W-1:0] pwm_cnt_reg;

	// clock select and source pick rate
	wire [fan_pkg::DIV_W-1:0] base_div = ({clk_sel, clk_src} == 2'b00) ? PWM_DIV0 :
	                                      ({clk_sel, clk_src} == 2'b01) ? PWM_DIV1 :
	                                      ({clk_sel, clk_src} == 2'b10) ? PWM_DIV2 : PWM_DIV3;
	wire [fan_pkg::DIV_W-1:0] pwm_div  = clk_mult ? (base_div >> 1) : base_div;
	// a shortened divider mid-count wraps at once instead of running long
	wire                      pwm_tick = (pwm_cnt_reg >= pwm_div - 1'b1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pwm_cnt_reg <= '0;
		else
			pwm_cnt_reg <= pwm_tick ? '0 : pwm_cnt_reg + 1'b1;
	end

	// ----------------------------------------
	// pwm waveform
	// ----------------------------------------
	logic [fan_pkg::DUTY_W-1:0] phase_reg;
	logic                       fan_pwm_reg;

	wire pwm_next = force_high || (phase_reg < duty);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg   <= '0;
			fan_pwm_reg <= 1'b0;
		end else begin
			phase_reg   <= pwm_tick ? phase_reg + 1'b1 : phase_reg;
			fan_pwm_reg <= pwm_next;
		end
	end

	assign fan_pwm_out = fan_pwm_reg;

	// ----------------------------------------
	// tach input and counting clock
	// ----------------------------------------
	logic                       tach_sync1_reg;
	logic                       tach_sync2_reg;
	logic                       tach_prev_reg;
	logic [fan_pkg::DIV_W-1:0]  tach_pre_reg;
	logic [fan_pkg::SCALE_W-1:0] scale_reg;

	wire tach_edge = tach_sync2_reg && !tach_prev_reg;
	wire base_tick = (tach_pre_reg >= TACH_DIV - 1'b1);
	// divisor code masks the scale counter
	wire tach_tick = base_tick && ((scale_reg & scale_mask(div_code)) == scale_mask(div_code));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tach_sync1_reg <= 1'b0;
			tach_sync2_reg <= 1'b0;
			tach_prev_reg  <= 1'b0;
			tach_pre_reg   <= '0;
			scale_reg      <= '0;
		end else begin
			tach_sync1_reg <= fan_tach_in;
			tach_sync2_reg <= tach_sync1_reg;
			tach_prev_reg  <= tach_sync2_reg;
			tach_pre_reg   <= base_tick ? '0 : tach_pre_reg + 1'b1;
			scale_reg      <= base_tick ? scale_reg + 1'b1 : scale_reg;
		end
	end

	// preload write restarts with new value
	wire [fan_pkg::TACH_W-1:0] preload_now = wr_start ? hwdata[7:0] : tach_start_value_reg;

	tach_counter #(
		.WIDTH         (fan_pkg::TACH_W)
	) u_tach (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.count_tick    (tach_tick),
		.pulse_edge    (tach_edge),
		.restart       (wr_start),
		.preload       (preload_now),
		.latched_count (tach_pulse_count)
	);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_preload_write;
		addr_take && hwrite && (haddr == {22'h000000, fan_pkg::IDX_TACH_START, 2'b00}) ##1 1'b1;
	endsequence

	sequence s_force_set;
		force_high [*2];
	endsequence

	a_force_high : assert property (@(posedge hclk) disable iff (!hresetn)
		s_force_set |-> fan_pwm_reg)
		else $error("fan pin not high while forced");

	a_duty_zero : assert property (@(posedge hclk) disable iff (!hresetn)
		(!force_high && duty == 6'h00) [*2] |-> !fan_pwm_reg)
		else $error("fan pin high with zero duty");

	a_duty_full_low : assert property (@(posedge hclk) disable iff (!hresetn)
		!force_high && duty == 6'h3f && phase_reg == 6'h3f |=> !fan_pwm_reg)
		else $error("full duty missed its one low step");

	a_step_spacing : assert property (@(posedge hclk) disable iff (!hresetn)
		pwm_tick && $stable(fan_clock_control_reg) && $stable(clk_sel) |=> !pwm_tick)
		else $error("pwm step came too soon");

	a_mult_halves : assert property (@(posedge hclk) disable iff (!hresetn)
		clk_mult |-> pwm_div == {1'b0, base_div[fan_pkg::DIV_W-1:1]})
		else $error("multiplier did not halve the step period");

	a_div_one : assert property (@(posedge hclk) disable iff (!hresetn)
		div_code == 2'b00 && base_tick |-> tach_tick)
		else $error("divide by one dropped a tach tick");

	a_div_eight : assert property (@(posedge hclk) disable iff (!hresetn)
		div_code == 2'b11 && tach_tick |-> scale_reg == 3'h7)
		else $error("divide by eight ticked early");

	a_preload_restart : assert property (@(posedge hclk) disable iff (!hresetn)
		s_preload_write |-> wr_start ##1 tach_start_value_reg == $past(hwdata[7:0]))
		else $error("preload write did not restart the count");

	a_count_readback : assert property (@(posedge hclk) disable iff (!hresetn)
		addr_take && !hwrite && (haddr == {22'h000000, fan_pkg::IDX_TACH_CNT, 2'b00})
		|=> hrdata_reg == {24'h000000, $past(tach_pulse_count)})
		else $error("tach count read back wrong");

	// per-cycle checks of the waveform, the counting clock and the tach edge detect
	a_duty_high : assert property (@(posedge hclk) disable iff (!hresetn)
		!force_high && phase_reg < duty |=> fan_pwm_reg)
		else $error("fan pin low inside the duty span");

	a_duty_low : assert property (@(posedge hclk) disable iff (!hresetn)
		!force_high && phase_reg >= duty |=> !fan_pwm_reg)
		else $error("fan pin high past the duty span");

	a_phase_step : assert property (@(posedge hclk) disable iff (!hresetn)
		pwm_tick |=> phase_reg == $past(phase_reg) + 1'b1)
		else $error("pwm phase did not advance on its step");

	a_step_wrap : assert property (@(posedge hclk) disable iff (!hresetn)
		pwm_tick |=> pwm_cnt_reg == '0)
		else $error("pwm divider did not wrap on its step");

	a_mult_off : assert property (@(posedge hclk) disable iff (!hresetn)
		!clk_mult |-> pwm_div == base_div)
		else $error("step period changed without multiplier");

	a_div_two : assert property (@(posedge hclk) disable iff (!hresetn)
		div_code == 2'b01 && tach_tick |-> scale_reg[0])
		else $error("divide by two ticked early");

	a_base_wrap : assert property (@(posedge hclk) disable iff (!hresetn)
		base_tick |=> tach_pre_reg == '0)
		else $error("tach prescaler did not wrap");

	a_edge_single : assert property (@(posedge hclk) disable iff (!hresetn)
		tach_edge |=> !tach_edge)
		else $error("one tach rise gave two edges");

	a_edge_synced : assert property (@(posedge hclk) disable iff (!hresetn)
		tach_edge |-> $past(tach_sync1_reg))
		else $error("tach edge skipped the synchroniser");

endmodule : fan_pwm_and_tachometer

// file: verification/fan_model.sv
`timescale 1ns/1ns
module fan_model (
	// clock
	input  wire logic hclk,
	// fan side
	input  int        period,
	output logic      fan_tach_in
);
	int   cnt      = 0;
	logic tach_reg = 1'b0;

	// ----
	// tach pulse train, one rising edge per period
	// ----
	// a stopped fan leaves the line low, so no edges reach the counter
	always @(posedge hclk) begin
		if (period == 0) begin
			cnt      <= 0;
			tach_reg <= 1'b0;
		end else begin
			cnt      <= (cnt >= period - 1) ? 0 : cnt + 1;
			tach_reg <= (cnt < period / 2);
		end
	end

	assign fan_tach_in = tach_reg;
endmodule : fan_model

// file: verification/fan_pwm_and_tachometer_tb_top.sv
`timescale 1ns/1ns
module fan_pwm_and_tachometer_tb_top;
	localparam int DV[4] = '{4, 6, 8, 10};
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        fan_tach_in;
	logic        fan_pwm_out;
	int          period;
	int          fails;
	int          total_checks;
	int          e;
	logic [7:0]  seed;
	logic [7:0]  m_out;
	logic [7:0]  m_clk;
	logic [7:0]  m_pre;

	fan_pwm_and_tachometer #(.PWM_DIV0(16'h0004), .PWM_DIV1(16'h0006), .PWM_DIV2(16'h0008),
		.PWM_DIV3(16'h000a), .TACH_DIV(16'h0004)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .fan_tach_in(fan_tach_in), .fan_pwm_out(fan_pwm_out));
	fan_model i_fan (.hclk(hclk), .period(period), .fan_tach_in(fan_tach_in));

	always #5 hclk = ~hclk;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// ----
	// ahb-lite single word transfer, waits on hready both phases
	// ----
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'b00};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, idx, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, idx, 32'h0, r);
		chk(r, exp);
	endtask : rd

	// ----
	// count pwm high cycles over one whole period
	// ----
	// a whole period makes the count independent of phase alignment
	task automatic pwm_chk();
		int d;
		int hi;
		wr(fan_pkg::IDX_FAN_OUT, {24'h0, m_out});
		wr(fan_pkg::IDX_FAN_CLK, {24'h0, m_clk});
		d = DV[{m_out[7], m_clk[0]}];
		if (m_clk[2]) d = d / 2;
		hi = 0;
		repeat (700) @(posedge hclk);
		repeat (64 * d) begin
			@(posedge hclk);
			hi += fan_pwm_out;
		end
		chk(hi, m_out[0] ? 64 * d : m_out[6:1] * d);
	endtask : pwm_chk

	task automatic test_done();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (60000) @(posedge hclk);
		fails++;
		test_done();
	end

	initial begin
		hclk = 1'b0;
		hresetn <= 1'b0;
		hsel <= 1'b0;
		haddr <= 32'h0;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hsize <= 3'b010;
		hwdata <= 32'h0;
		period <= 0;
		seed = 8'h54;
		fails = 0;
		total_checks = 0;
		repeat (3) @(posedge hclk);
		chk({30'h0, hreadyout, fan_pwm_out}, 32'h0);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		// ----
		// reset values, access kinds, unmapped space
		// ----
		rd(fan_pkg::IDX_FAN_OUT, 32'h00);
		rd(fan_pkg::IDX_FAN_CLK, 32'h10);
		rd(fan_pkg::IDX_TACH_CNT, 32'h00);
		rd(fan_pkg::IDX_TACH_START, 32'h00);
		wr(fan_pkg::IDX_FAN_CLK, 32'hff);
		rd(fan_pkg::IDX_FAN_CLK, 32'h35);
		wr(fan_pkg::IDX_TACH_CNT, 32'hff);
		rd(fan_pkg::IDX_TACH_CNT, 32'h00);
		wr(fan_pkg::IDX_TACH_START, 32'h5a);
		rd(fan_pkg::IDX_TACH_START, 32'h5a);
		wr(8'h5a, 32'h77);
		rd(8'h5a, 32'h00);
		rd(fan_pkg::IDX_FAN_OUT, 32'h00);
		// ----
		// every clock select and multiplier setting
		// ----
		for (int s = 0; s < 8; s++) begin
			m_out = {s[1], 6'd32, 1'b0};
			m_clk = {4'h1, 1'b0, s[2], 1'b0, s[0]};
			pwm_chk();
		end
		// ----
		// duty boundaries, random duty, forced high
		// ----
		for (int k = 0; k < 5; k++) begin
			seed = lfsr(seed);
			case (k)
				0: m_out = 8'h00;
				1: m_out = 8'h7e;
				2: m_out = 8'h02;
				3: m_out = seed & 8'h7e;
				default: m_out = seed | 8'h01;
			endcase
			m_clk = 8'h10;
			pwm_chk();
		end
		// ----
		// tach count per divisor
		// ----
		// readings are taken after three pulses, past the unsettled span
		period <= 320;
		for (int dv = 0; dv < 5; dv++) begin
			seed = lfsr(seed);
			m_pre = (dv == 4) ? 8'h60 : {1'b0, seed[6:0]};
			m_clk = (dv == 4) ? 8'h00 : {2'b0, dv[1:0], 4'h0};
			if (dv == 4) period <= 640;
			wr(fan_pkg::IDX_FAN_CLK, {24'h0, m_clk});
			wr(fan_pkg::IDX_TACH_START, {24'h0, m_pre});
			repeat (3 * period + 40) @(posedge hclk);
			e = m_pre + period / (4 << m_clk[5:4]);
			if (e > 255) e = 255;
			rd(fan_pkg::IDX_TACH_CNT, e);
		end
		test_done();
	end
endmodule : fan_pwm_and_tachometer_tb_top
